// ===== core/rtcb_pkg.sv
// constants, types and states of the circular buffer manager (mode one)
// assumes a 16-bit shared RAM and a 16-bit host configuration port
package rtcb_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;

	// descriptor control word fields
	localparam int CW_IRQ_POS = 15;
	localparam int CW_PP_POS = 14;
	localparam int CW_C2_POS = 13;
	localparam int CW_C1_POS = 12;

	// descriptor word offsets from base N
	localparam logic [15:0] DESC_CTRL_OFS = 16'h0000;
	localparam logic [15:0] DESC_START_OFS = 16'h0001;
	localparam logic [15:0] DESC_CUR_OFS = 16'h0002;
	localparam logic [15:0] DESC_END_OFS = 16'h0003;
	localparam logic [1:0] DESC_LAST = 2'h3;

	// info word, time-tag word, then data
	localparam logic [15:0] TTAG_OFS = 16'h0001;
	localparam logic [15:0] DATA_OFS = 16'h0002;
	localparam logic [15:0] PTR_STEP = 16'h0001;

	localparam logic [15:0] CFG2_OFS = 16'h0001;
	localparam logic [15:0] CFG2_RESET = 16'h0000;
	localparam int CFG2_BCFLAG_POS = 3;
	localparam int MIW_BROADCAST_MSG_FLAG_POS = 13;

	localparam logic [4:0] BROADCAST_MSG_FLAG_RT_ADDR = 5'h1f;
	localparam logic [4:0] MODE_SA_LO = 5'h00;
	localparam logic [4:0] MODE_SA_HI = 5'h1f;

	typedef struct packed {
		logic [4:0] rt;
		logic tr;
		logic [4:0] sa;
		logic [4:0] wc;
	} rtcb_cmd_t;

	typedef struct packed {
		logic err;
		logic busy;
		logic illegal;
		logic gap_err;
		logic [15:0] info;
		logic [15:0] ttag;
	} rtcb_end_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DESC,
		ST_ACTIVE,
		ST_INFO,
		ST_TTAG,
		ST_CUR
	} rtcb_state_t;

endpackage : rtcb_pkg

// ===== core/rtcb_core.sv
// circular buffer manager, mode one, for one remote terminal
// assumes a RAM whose read data is valid the cycle after RAM_RE_O,
// and a protocol engine on the same clock that frames each message
`timescale 1ns/10ps

// Summary of operation
// - Mode applies when pingpong and circ_two are 0 and circ_one is 1.
// - Mode code commands never use this mode.
// - Descriptor: control at N, start N+1, current N+2, end N+3.
// - Descriptor chosen from T/R bit and subaddress fields only.
// - Start and end pointers are only read; current pointer written back.
// - Receive: info at current, time-tag at current+1, data from current+2.
// - Transmit: first data word fetched from current+2.
// - Info and time-tag words written after message completes.
// - Receive ok: current = last stored+1 if not above end, else start.
// - Transmit ok: current = last read+1 if not above end, else start.
// - Wrap only after message end; accesses may pass the end pointer.
// - Receive wrap with both irq enables set pulses the message interrupt.
// - Transmit wrap with both irq enables set pulses the message interrupt.
// - Error, busy or illegal: info words written, pointer unchanged.
// - Broadcast and non-broadcast receive data share the buffer.
// - Config two bit 3 puts broadcast flag in info bit 13.
// - Broadcast transmit: nothing sent, info words written, pointer kept.
module rtcb_core #(
	parameter logic [15:0] DESC_BASE = 16'h0000
) (
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	input wire logic MSG_START_I,
	input wire rtcb_pkg::rtcb_cmd_t CMD_WORD_I,
	input wire logic RX_WORD_VALID_I,
	input wire logic [15:0] RX_WORD_I,
	input wire logic TX_WORD_REQ_I,
	input wire logic MSG_END_I,
	input wire rtcb_pkg::rtcb_end_t MSG_END_INFO_I,
	input wire logic IRQ_ENABLE_I,
	input wire logic CFG_WE_I,
	input wire logic [15:0] CFG_ADDR_I,
	input wire logic [15:0] CFG_WDATA_I,
	input wire logic [15:0] RAM_RDATA_I,
	output logic [15:0] CFG_RDATA_O,
	output logic [15:0] RAM_ADDR_O,
	output logic [15:0] RAM_WDATA_O,
	output logic RAM_WE_O,
	output logic RAM_RE_O,
	output logic [15:0] TX_WORD_O,
	output logic TX_WORD_VALID_O,
	output logic CIRC_ACTIVE_O,
	output logic [15:0] CUR_PTR_O,
	output logic MESSAGE_IRQ_O
);

	generate
		if (DESC_BASE[1:0] != 2'h0)
		begin : g_base_chk
			$error("descriptor base must be four-word aligned");
		end
	endgenerate

	rtcb_pkg::rtcb_state_t state_q;
	rtcb_pkg::rtcb_cmd_t cmd_q;
	rtcb_pkg::rtcb_end_t end_q;
	logic [15:0] cfg2_q;
	logic [15:0] desc_q;
	logic [15:0] ctrl_q;
	logic [15:0] start_q;
	logic [15:0] cur_q;
	logic [15:0] end_ptr_q;
	logic [15:0] ptr_q;
	logic [1:0] iss_q;
	logic iss_done_q;
	logic desc_pend_q;
	logic [1:0] pidx_q;
	logic tx_pend_q;
	logic irq_q;
	logic [15:0] info_d;
	logic [15:0] cur_d;
	logic wrap_d;
	logic ok_d;
	logic bc_tx_d;

	// subaddress commands index by T/R and subaddress; the word count
	// field would only pick a mode code block, which this mode never uses
	function automatic logic [15:0] desc_addr(input rtcb_pkg::rtcb_cmd_t c);
		logic [15:0] idx;
		idx = {10'h000, c.tr, c.sa};
		desc_addr = DESC_BASE + {idx[13:0], 2'b00};
	endfunction : desc_addr

	function automatic logic is_mode_cmd(input rtcb_pkg::rtcb_cmd_t c);
		is_mode_cmd = (c.sa == rtcb_pkg::MODE_SA_LO) || (c.sa == rtcb_pkg::MODE_SA_HI);
	endfunction : is_mode_cmd

	function automatic logic circ_one_sel(input logic [15:0] cw);
		circ_one_sel = !cw[rtcb_pkg::CW_PP_POS] && !cw[rtcb_pkg::CW_C2_POS] && cw[rtcb_pkg::CW_C1_POS];
	endfunction : circ_one_sel

	// info word with bit 13 chosen between broadcast and gap error
	always_comb
	begin
		info_d = end_q.info;
		if (cfg2_q[rtcb_pkg::CFG2_BCFLAG_POS])
		begin
			info_d[rtcb_pkg::MIW_BROADCAST_MSG_FLAG_POS] = (cmd_q.rt == rtcb_pkg::BROADCAST_MSG_FLAG_RT_ADDR);
		end
		else
		begin
			info_d[rtcb_pkg::MIW_BROADCAST_MSG_FLAG_POS] = end_q.gap_err;
		end
	end

	// ptr_q already holds last accessed address plus one
	always_comb
	begin
		bc_tx_d = cmd_q.tr && (cmd_q.rt == rtcb_pkg::BROADCAST_MSG_FLAG_RT_ADDR);
		ok_d = !end_q.err && !end_q.busy && !end_q.illegal && !bc_tx_d;
		wrap_d = ptr_q > end_ptr_q;
		cur_d = wrap_d ? start_q : ptr_q;
	end

	// host configuration register two
	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I)
		begin
			cfg2_q <= rtcb_pkg::CFG2_RESET;
		end
		else if (CFG_WE_I && (CFG_ADDR_I == rtcb_pkg::CFG2_OFS))
		begin
			cfg2_q <= CFG_WDATA_I;
		end
	end

	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I)
		begin
			CFG_RDATA_O <= rtcb_pkg::CFG2_RESET;
		end
		else
		begin
			CFG_RDATA_O <= cfg2_q;
		end
	end

	// message sequencer and RAM port
	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I)
		begin
			state_q <= rtcb_pkg::ST_IDLE;
			cmd_q <= '0;
			end_q <= '0;
			desc_q <= 16'h0000;
			ptr_q <= 16'h0000;
			iss_q <= 2'h0;
			iss_done_q <= 1'b0;
			RAM_ADDR_O <= 16'h0000;
			RAM_WDATA_O <= 16'h0000;
			RAM_WE_O <= 1'b0;
			RAM_RE_O <= 1'b0;
		end
		else
		begin
			RAM_WE_O <= 1'b0;
			RAM_RE_O <= 1'b0;
			unique case (state_q)
				rtcb_pkg::ST_IDLE:
				begin
					if (MSG_START_I && !is_mode_cmd(CMD_WORD_I))
					begin
						cmd_q <= CMD_WORD_I;
						desc_q <= desc_addr(CMD_WORD_I);
						iss_q <= 2'h0;
						iss_done_q <= 1'b0;
						state_q <= rtcb_pkg::ST_DESC;
					end
				end
				rtcb_pkg::ST_DESC:
				begin
					// four back-to-back reads of the block at N
					if (!iss_done_q)
					begin
						RAM_RE_O <= 1'b1;
						RAM_ADDR_O <= desc_q + {14'h0000, iss_q};
						iss_q <= iss_q + 2'h1;
						iss_done_q <= (iss_q == rtcb_pkg::DESC_LAST);
					end
					if (desc_pend_q && (pidx_q == rtcb_pkg::DESC_LAST))
					begin
						if (circ_one_sel(ctrl_q))
						begin
							ptr_q <= cur_q + rtcb_pkg::DATA_OFS;
							state_q <= rtcb_pkg::ST_ACTIVE;
						end
						else
						begin
							state_q <= rtcb_pkg::ST_IDLE;
						end
					end
				end
				rtcb_pkg::ST_ACTIVE:
				begin
					if (MSG_END_I)
					begin
						end_q <= MSG_END_INFO_I;
						state_q <= rtcb_pkg::ST_INFO;
					end
					else if (RX_WORD_VALID_I && !cmd_q.tr)
					begin
						// broadcast data lands in the same buffer
						RAM_WE_O <= 1'b1;
						RAM_ADDR_O <= ptr_q;
						RAM_WDATA_O <= RX_WORD_I;
						ptr_q <= ptr_q + rtcb_pkg::PTR_STEP;
					end
					else if (TX_WORD_REQ_I && cmd_q.tr && (cmd_q.rt != rtcb_pkg::BROADCAST_MSG_FLAG_RT_ADDR))
					begin
						RAM_RE_O <= 1'b1;
						RAM_ADDR_O <= ptr_q;
						ptr_q <= ptr_q + rtcb_pkg::PTR_STEP;
					end
				end
				rtcb_pkg::ST_INFO:
				begin
					RAM_WE_O <= 1'b1;
					RAM_ADDR_O <= cur_q;
					RAM_WDATA_O <= info_d;
					state_q <= rtcb_pkg::ST_TTAG;
				end
				rtcb_pkg::ST_TTAG:
				begin
					RAM_WE_O <= 1'b1;
					RAM_ADDR_O <= cur_q + rtcb_pkg::TTAG_OFS;
					RAM_WDATA_O <= end_q.ttag;
					if (ok_d)
					begin
						state_q <= rtcb_pkg::ST_CUR;
					end
					else
					begin
						state_q <= rtcb_pkg::ST_IDLE;
					end
				end
				rtcb_pkg::ST_CUR:
				begin
					// only the current pointer word is ever written back
					RAM_WE_O <= 1'b1;
					RAM_ADDR_O <= desc_q + rtcb_pkg::DESC_CUR_OFS;
					RAM_WDATA_O <= cur_d;
					state_q <= rtcb_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// descriptor capture, one cycle behind each read
	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I)
		begin
			desc_pend_q <= 1'b0;
			pidx_q <= 2'h0;
			ctrl_q <= 16'h0000;
			start_q <= 16'h0000;
			cur_q <= 16'h0000;
			end_ptr_q <= 16'h0000;
		end
		else
		begin
			// track the read actually issued; its data is valid one cycle later
			desc_pend_q <= RAM_RE_O && (state_q == rtcb_pkg::ST_DESC);
			pidx_q <= RAM_ADDR_O[1:0];
			if (state_q == rtcb_pkg::ST_CUR)
			begin
				cur_q <= cur_d;
			end
			else if (desc_pend_q)
			begin
				unique case (pidx_q)
					2'h0: ctrl_q <= RAM_RDATA_I;
					2'h1: start_q <= RAM_RDATA_I;
					2'h2: cur_q <= RAM_RDATA_I;
					2'h3: end_ptr_q <= RAM_RDATA_I;
				endcase
			end
		end
	end

	// transmit word return path
	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I)
		begin
			tx_pend_q <= 1'b0;
			TX_WORD_O <= 16'h0000;
			TX_WORD_VALID_O <= 1'b0;
		end
		else
		begin
			tx_pend_q <= RAM_RE_O && (state_q == rtcb_pkg::ST_ACTIVE);
			TX_WORD_VALID_O <= tx_pend_q;
			if (tx_pend_q)
			begin
				TX_WORD_O <= RAM_RDATA_I;
			end
		end
	end

	// interrupt pulse on wrap; one flag serves full and empty
	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I)
		begin
			irq_q <= 1'b0;
		end
		else
		begin
			irq_q <= (state_q == rtcb_pkg::ST_CUR) && wrap_d && ctrl_q[rtcb_pkg::CW_IRQ_POS]
				&& IRQ_ENABLE_I;
		end
	end

	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I)
		begin
			MESSAGE_IRQ_O <= 1'b0;
			CIRC_ACTIVE_O <= 1'b0;
			CUR_PTR_O <= 16'h0000;
		end
		else
		begin
			MESSAGE_IRQ_O <= irq_q;
			CIRC_ACTIVE_O <= (state_q == rtcb_pkg::ST_ACTIVE);
			CUR_PTR_O <= cur_q;
		end
	end

endmodule : rtcb_core

// ===== testbench/rtcb_core_monitor.sv
// port checker for the circular buffer manager
// assumes the single clock and synchronous reset of rtcb_core
`timescale 1ns/10ps
module rtcb_core_monitor #(
	parameter logic [15:0] DESC_BASE = 16'h0000
) (
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	input wire logic MSG_START_I,
	input wire logic MSG_END_I,
	input wire rtcb_pkg::rtcb_end_t MSG_END_INFO_I,
	input wire logic RX_WORD_VALID_I,
	input wire logic CFG_WE_I,
	input wire logic [15:0] CFG_ADDR_I,
	input wire logic [15:0] CFG_WDATA_I,
	input wire logic [15:0] CFG_RDATA_O,
	input wire logic [15:0] RAM_ADDR_O,
	input wire logic RAM_WE_O,
	input wire logic RAM_RE_O,
	input wire logic TX_WORD_VALID_O,
	input wire logic CIRC_ACTIVE_O,
	input wire logic MESSAGE_IRQ_O
);
	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (RST_I);
	sequence s_recs;
		##2 RAM_WE_O ##1 (RAM_WE_O && RAM_ADDR_O == $past(RAM_ADDR_O) + 16'h0001);
	endsequence
	sequence s_quiet;
		##4 !RAM_WE_O ##1 !MESSAGE_IRQ_O;
	endsequence
	property p_active;
		$rose(CIRC_ACTIVE_O) |-> $past(MSG_START_I, 8);
	endproperty
	a_active: assert property (p_active) else $error("active without start");
	property p_rx;
		RX_WORD_VALID_I && CIRC_ACTIVE_O |=> RAM_WE_O;
	endproperty
	a_rx: assert property (p_rx) else $error("rx word not stored");
	property p_tx;
		TX_WORD_VALID_O |-> $past(RAM_RE_O, 2);
	endproperty
	a_tx: assert property (p_tx) else $error("tx word not fetched");
	property p_recs;
		MSG_END_I && CIRC_ACTIVE_O |-> s_recs;
	endproperty
	a_recs: assert property (p_recs) else $error("info words missing");
	property p_err;
		MSG_END_I && CIRC_ACTIVE_O && MSG_END_INFO_I.err |-> s_quiet;
	endproperty
	a_err: assert property (p_err) else $error("pointer moved on error");
	// only the current pointer word of a descriptor may be written
	property p_desc;
		RAM_WE_O && ((RAM_ADDR_O - DESC_BASE) < 16'h0100) |-> RAM_ADDR_O[1:0] == 2'h2;
	endproperty
	a_desc: assert property (p_desc) else $error("descriptor word written");
	property p_irq;
		MESSAGE_IRQ_O |-> $past(MSG_END_I, 5);
	endproperty
	a_irq: assert property (p_irq) else $error("stray interrupt");
	property p_cfg;
		CFG_WE_I && CFG_ADDR_I == 16'h0001 |-> ##2 CFG_RDATA_O == $past(CFG_WDATA_I, 2);
	endproperty
	a_cfg: assert property (p_cfg) else $error("config not stored");
endmodule : rtcb_core_monitor
bind rtcb_core rtcb_core_monitor #(.DESC_BASE(DESC_BASE)) u_rtcb_core_monitor (.*);

// ===== testbench/rtcb_ram.sv
// shared RAM partner, read data valid the cycle after a read
// assumes 4096 words suffice; the address is cut to 12 bits
`timescale 1ns/10ps
module rtcb_ram (
	input wire logic clk_i,
	input wire logic re_i,
	input wire logic we_i,
	input wire logic [15:0] addr_i,
	input wire logic [15:0] wdata_i,
	output logic [15:0] rdata_o
);
	logic [15:0] mem [0:4095];
	// stale data toggles so a late sample cannot pass by luck
	always @(posedge clk_i)
	begin
		if (re_i)
			rdata_o <= mem[addr_i[11:0]];
		else
			rdata_o <= ~rdata_o;
		if (we_i)
			mem[addr_i[11:0]] <= wdata_i;
	end
endmodule : rtcb_ram

// ===== testbench/test_rtcb_core.sv
// testbench for the circular buffer manager
// assumes rtcb_ram as shared memory and the bound port checker
`timescale 1ns/10ps
module test_rtcb_core;
	logic SYS_CLK_I, RST_I, MSG_START_I, RX_WORD_VALID_I, TX_WORD_REQ_I, MSG_END_I, IRQ_ENABLE_I, CFG_WE_I;
	logic [15:0] RX_WORD_I, CFG_ADDR_I, CFG_WDATA_I, RAM_RDATA_I, CFG_RDATA_O, RAM_ADDR_O, RAM_WDATA_O;
	logic [15:0] TX_WORD_O, CUR_PTR_O;
	logic RAM_WE_O, RAM_RE_O, TX_WORD_VALID_O, CIRC_ACTIVE_O, MESSAGE_IRQ_O;
	rtcb_pkg::rtcb_cmd_t CMD_WORD_I;
	rtcb_pkg::rtcb_end_t MSG_END_INFO_I;
	int num_errors = 0;
	int n_tests = 0;
	int irqs = 0;
	int wes = 0;
	int i0;
	rtcb_core u_rtcb_core (.*);
	rtcb_ram u_rtcb_ram (.clk_i(SYS_CLK_I), .re_i(RAM_RE_O), .we_i(RAM_WE_O), .addr_i(RAM_ADDR_O),
		.wdata_i(RAM_WDATA_O), .rdata_o(RAM_RDATA_I));
	initial
	begin
		SYS_CLK_I = 1'b0;
		forever #20 SYS_CLK_I = ~SYS_CLK_I;
	end
	always @(posedge SYS_CLK_I)
	begin
		irqs += int'(MESSAGE_IRQ_O === 1'b1);
		wes += int'(RAM_WE_O === 1'b1);
	end
	task results;
		if (num_errors == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results
	task chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e)
		begin
			num_errors++;
			$display("FAIL %0t %h %h", $time, g, e);
		end
	endtask : chk
	function automatic logic [15:0] m(input logic [15:0] a);
		return u_rtcb_ram.mem[a[11:0]];
	endfunction : m
	task ld(input logic [15:0] a, input logic [15:0] d);
		u_rtcb_ram.mem[a[11:0]] = d;
	endtask : ld
	task tk(input int n);
		repeat (n) @(posedge SYS_CLK_I);
	endtask : tk
	task cfg(input logic [15:0] a, input logic [15:0] d);
		@(posedge SYS_CLK_I);
		CFG_WE_I <= 1'b1;
		CFG_ADDR_I <= a;
		CFG_WDATA_I <= d;
		@(posedge SYS_CLK_I);
		CFG_WE_I <= 1'b0;
	endtask : cfg
	// one message: command, n data strobes, then the end report
	task msg(input logic [15:0] c, input int n, input logic e, input logic t);
		int k;
		int w;
		@(posedge SYS_CLK_I);
		MSG_START_I <= 1'b1;
		CMD_WORD_I <= c;
		@(posedge SYS_CLK_I);
		MSG_START_I <= 1'b0;
		tk(10);
		for (k = 0; k < n; k++)
		begin
			RX_WORD_I <= 16'h00a0 + 16'(k);
			RX_WORD_VALID_I <= !t;
			TX_WORD_REQ_I <= t;
			@(posedge SYS_CLK_I);
			RX_WORD_VALID_I <= 1'b0;
			TX_WORD_REQ_I <= 1'b0;
			for (w = 0; w < 6 && TX_WORD_VALID_O !== 1'b1; w++)
				@(negedge SYS_CLK_I);
			if (t && w == 6)
			begin
				num_errors++;
				results();
			end
			if (t)
				chk(TX_WORD_O, 16'h5a01 + 16'(k));
			@(posedge SYS_CLK_I);
		end
		MSG_END_I <= 1'b1;
		MSG_END_INFO_I <= {e, 3'h0, 16'h0041, 16'h00cc};
		@(posedge SYS_CLK_I);
		MSG_END_I <= 1'b0;
		tk(10);
	endtask : msg
	task s_rx;
		msg(16'h0823, 3, 1'b0, 1'b0);
		chk(m(16'h0100), 16'h0041);
		chk(m(16'h0101), 16'h00cc);
		chk(m(16'h0104), 16'h00a2);
		chk(m(16'h0006), 16'h0105);
		chk(CUR_PTR_O, 16'h0105);
	endtask : s_rx
	task s_wrap;
		i0 = irqs;
		msg(16'h0821, 1, 1'b0, 1'b0);
		chk(m(16'h0107), 16'h00a0);
		chk(m(16'h0006), 16'h0100);
		chk(16'(irqs - i0), 16'h0001);
	endtask : s_wrap
	task s_err;
		i0 = irqs;
		ld(16'h0100, 16'h0000);
		msg(16'h0823, 2, 1'b1, 1'b0);
		chk(m(16'h0100), 16'h0041);
		chk(m(16'h0006), 16'h0100);
		chk(16'(irqs - i0), 16'h0000);
	endtask : s_err
	task s_cfg;
		chk(CFG_RDATA_O, 16'h0000);
		cfg(16'h0001, 16'h0008);
		cfg(16'h0002, 16'hffff);
		tk(3);
		chk(CFG_RDATA_O, 16'h0008);
		msg(16'hf821, 1, 1'b0, 1'b0);
		chk(m(16'h0100), 16'h2041);
		chk(m(16'h0102), 16'h00a0);
		chk(m(16'h0006), 16'h0103);
	endtask : s_cfg
	task s_tx;
		i0 = irqs;
		msg(16'h0c42, 2, 1'b0, 1'b1);
		chk(m(16'h0200), 16'h0041);
		chk(m(16'h008a), 16'h0200);
		chk(16'(irqs - i0), 16'h0001);
		msg(16'hfc42, 0, 1'b0, 1'b1);
		chk(m(16'h0200), 16'h2041);
		chk(m(16'h008a), 16'h0200);
		// wrap with the IRQ_ENABLE_I input low must stay silent
		i0 = irqs;
		IRQ_ENABLE_I <= 1'b0;
		msg(16'h0c42, 2, 1'b0, 1'b1);
		chk(16'(irqs - i0), 16'h0000);
		IRQ_ENABLE_I <= 1'b1;
	endtask : s_tx
	task s_mode;
		i0 = wes;
		msg(16'h0801, 0, 1'b0, 1'b0);
		chk(16'(wes - i0), 16'h0000);
		msg(16'h0861, 0, 1'b0, 1'b0);
		chk(16'(wes - i0), 16'h0000);
		chk(m(16'h0005), 16'h0100);
		chk(m(16'h0007), 16'h0105);
	endtask : s_mode
	initial
	begin
		RST_I = 1'b1;
		{MSG_START_I, RX_WORD_VALID_I, TX_WORD_REQ_I, MSG_END_I, CFG_WE_I} = 5'h00;
		{RX_WORD_I, CFG_ADDR_I, CFG_WDATA_I} = 48'h0;
		CMD_WORD_I = 16'h0000;
		MSG_END_INFO_I = 36'h0;
		IRQ_ENABLE_I = 1'b1;
		// descriptors with current equal to start
		ld(16'h0004, 16'h9000);
		ld(16'h0005, 16'h0100);
		ld(16'h0006, 16'h0100);
		ld(16'h0007, 16'h0105);
		ld(16'h0088, 16'h9000);
		ld(16'h0089, 16'h0200);
		ld(16'h008a, 16'h0200);
		ld(16'h008b, 16'h0203);
		ld(16'h0202, 16'h5a01);
		ld(16'h0203, 16'h5a02);
		ld(16'h0000, 16'h9000);
		ld(16'h000c, 16'hd000);
		tk(2);
		RST_I <= 1'b0;
		tk(2);
		s_rx();
		s_wrap();
		s_err();
		s_cfg();
		s_tx();
		s_mode();
		results();
	end
endmodule : test_rtcb_core
